// ==== design/ccgms_pkg.sv ====
// Operation
// R1: software copies the control register's upper half into the configuration latch
// R2: three mode bits decode into ratios x4, x3, x2, x5, x1, x1.5, /2, x2.5
// R3: mode 001 derives the cpu clock from the oscillator through a two-to-one prescaler
// R4: in prescaler mode each cpu clock phase lasts one oscillator period
// R5: multiplying modes enable the loop and source the cpu clock from it
// R6: multiplied clock realigns to the input every factor-count oscillator transitions
// R7: each realignment is gradual, never a sudden frequency step
// R8: in host emulation mode the top strap bit is inverted before use
// R9: modes change only from the latch, and the cpu clock stays glitch-free
package ccgms_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ    = 50;
  localparam int unsigned MODE_SETTLE_NS  = 100;
  // least time, so round up to whole cycles
  localparam int unsigned MODE_SETTLE_CYC = (MODE_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam logic [2:0]  STRAP_WAIT      = 3'h4;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  RSTCTL_OFF      = 8'h00;
  localparam logic [7:0]  LATCH_OFF       = 8'h04;
  localparam logic [7:0]  STATUS_OFF      = 8'h08;
  localparam logic [15:0] RSTCTL_RESET    = 16'he000;
  localparam logic [7:0]  LATCH_RESET     = 8'he0;
  localparam int unsigned RELOAD_BIT      = 0;
  localparam int unsigned CFG_LSB         = 8;
  localparam int unsigned MODE_LSB        = 5;
  localparam int unsigned EMU_INV_BIT     = 2;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ----------------------------------------------------------------
  // clock mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  MODE_X4         = 3'h7;
  localparam logic [2:0]  MODE_X3         = 3'h6;
  localparam logic [2:0]  MODE_X2         = 3'h5;
  localparam logic [2:0]  MODE_X5         = 3'h4;
  localparam logic [2:0]  MODE_DIRECT     = 3'h3;
  localparam logic [2:0]  MODE_X1_5       = 3'h2;
  localparam logic [2:0]  MODE_PRESCALE   = 3'h1;
  localparam logic [2:0]  MODE_X2_5       = 3'h0;

  typedef enum logic [2:0] {
    KIND_DIRECT   = 3'b001,
    KIND_PRESCALE = 3'b010,
    KIND_PLL      = 3'b100
  } ccgms_kind_t;

  typedef enum logic [1:0] {
    SW_RUN  = 2'b01,
    SW_HOLD = 2'b10
  } ccgms_sw_state_t;

  // ratio as numerator over denominator
  typedef struct packed {
    ccgms_kind_t kind;
    logic [2:0]  num;
    logic [1:0]  den;
  } ccgms_ratio_t;

  // mode field to path and factor
  function automatic ccgms_ratio_t ccgms_decode(input logic [2:0] mode);
    ccgms_ratio_t r;
    r = '{kind: KIND_PLL, num: 3'h4, den: 2'h1};
    unique case (mode)
      MODE_X4:       r = '{kind: KIND_PLL,      num: 3'h4, den: 2'h1}; // R2
      MODE_X3:       r = '{kind: KIND_PLL,      num: 3'h3, den: 2'h1}; // R2
      MODE_X2:       r = '{kind: KIND_PLL,      num: 3'h2, den: 2'h1}; // R2
      MODE_X5:       r = '{kind: KIND_PLL,      num: 3'h5, den: 2'h1}; // R2
      MODE_DIRECT:   r = '{kind: KIND_DIRECT,   num: 3'h1, den: 2'h1}; // R2
      MODE_X1_5:     r = '{kind: KIND_PLL,      num: 3'h3, den: 2'h2}; // R2
      MODE_PRESCALE: r = '{kind: KIND_PRESCALE, num: 3'h1, den: 2'h2}; // R2
      MODE_X2_5:     r = '{kind: KIND_PLL,      num: 3'h5, den: 2'h2}; // R2
    endcase
    return r;
  endfunction : ccgms_decode

endpackage : ccgms_pkg

// ==== design/ccgms_pll.sv ====
`timescale 1ns/1ps
// digital multiplier: measures the oscillator period in system cycles and
// runs a phase accumulator at num/den times the oscillator rate
module ccgms_pll #(
  parameter int PER_W = 16
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             restart,
  input  wire logic [2:0]       mul_num,
  input  wire logic [1:0]       mul_den,
  // oscillator events, already filtered
  input  wire logic             osc_rise,
  input  wire logic             osc_edge,
  // results
  output logic                  clk_out,
  output logic                  locked,
  output logic [PER_W-1:0]      period
);

  typedef struct packed {
    logic [PER_W-1:0] cnt;
    logic [PER_W-1:0] per;
    logic             have;
    logic [PER_W+3:0] acc;
    logic             clk;
    logic [2:0]       edges;
    logic             up;
    logic             dn;
    logic             lock;
  } ccgms_pll_state_t;

  ccgms_pll_state_t q, d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [PER_W-1:0] meas;
    logic [PER_W+3:0] thr;
    logic [PER_W+3:0] inc;
    logic [PER_W+3:0] sum;
    meas = '0;
    thr  = '0;
    inc  = '0;
    sum  = '0;
    d    = q;
    if (q.cnt != '1) begin
      d.cnt = q.cnt + 1'b1;
    end
    // period tracking moves one count per oscillator rise, so the rate drifts, never jumps
    if (osc_rise) begin
      meas  = q.cnt + 1'b1;
      d.cnt = '0;
      if (!q.have) begin
        d.per  = meas;
        d.have = (q.cnt != '1); // a count begun at reset is no period
      end else if (meas > q.per) begin
        d.per = q.per + 1'b1; // R7
      end else if (meas < q.per) begin
        d.per = q.per - 1'b1; // R7
      end
      d.lock = q.have && (meas == q.per);
    end
    // accumulator: 2*num per cycle against per*den gives 2*F toggles per period
    thr = (PER_W+4)'(q.per) * (PER_W+4)'(mul_den);
    inc = (PER_W+4)'({mul_num, 1'b0});
    if (q.up) begin
      inc = inc + 1'b1; // R7
    end else if (q.dn) begin
      inc = inc - 1'b1; // R7
    end
    d.up = 1'b0;
    d.dn = 1'b0;
    if (q.have) begin
      sum = q.acc + inc;
      if (sum >= thr) begin
        d.acc = sum - thr;
        d.clk = ~q.clk; // R5
      end else begin
        d.acc = sum;
      end
    end
    // realign at every num-th oscillator transition by a one-step nudge
    if (osc_edge) begin
      if (q.edges + 1'b1 >= mul_num) begin
        d.edges = '0;
        if (q.have && q.clk) begin
          d.dn = 1'b1; // R6
        end else if (q.have && q.acc != '0) begin
          d.up = 1'b1; // R6
        end
      end else begin
        d.edges = q.edges + 1'b1;
      end
    end
    if (restart) begin
      d = '{cnt: d.cnt, per: d.per, have: d.have, default: '0};
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{cnt: '1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign clk_out = q.clk;
  assign locked  = q.lock;
  assign period  = q.per;

endmodule : ccgms_pll

// ==== design/ccgms_top.sv ====
`timescale 1ns/1ps
// cpu clock generator: picks direct, prescaled or multiplied path from the
// configuration latch and switches between them with the clock held low
module ccgms_top #(
  parameter int ADDR_W = 8,
  parameter int PER_W  = 16
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // pins
  input  wire logic              osc_in,
  input  wire logic [2:0]        clock_mode_strap_pins,
  input  wire logic              external_host_mode,
  // clock tree side
  output logic                   cpu_clk,
  output logic                   pll_enable
);

  typedef struct packed {
    // pin synchronisers
    logic [2:0]                osc_s;
    logic                      osc_lvl;
    logic [2:0]                strap_s1;
    logic [2:0]                strap_s2;
    logic [2:0]                strap_s3;
    logic [2:0]                strap_lvl;
    logic [2:0]                ehm_s;
    logic                      ehm_lvl;
    logic [2:0]                strap_cnt;
    logic                      strap_done;
    // registers
    logic [15:0]               rstctl;
    logic [7:0]                latch;
    // mode switching
    logic [2:0]                active;
    ccgms_pkg::ccgms_sw_state_t sw_state;
    logic [7:0]                settle;
    logic                      cpu_clk;
    logic                      pll_en;
    // bus
    logic                      aw_have;
    logic [ADDR_W-1:0]         awaddr;
    logic                      w_have;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      awready;
    logic                      wready;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
  } ccgms_core_state_t;

  ccgms_core_state_t q, d;

  logic                 osc_rise;
  logic                 osc_edge;
  logic                 pll_restart;
  logic                 pll_clk;
  logic                 pll_locked;
  logic [PER_W-1:0]     pll_period;
  ccgms_pkg::ccgms_ratio_t ratio_q;

  // ----------------------------------------------------------------
  // multiplier path
  // ----------------------------------------------------------------
  // ratio of the running mode, never of the latch, so a reload mid-run
  // cannot disturb the multiplier before the switch sequence starts
  assign ratio_q     = ccgms_pkg::ccgms_decode(q.active);
  assign osc_edge    = (q.osc_s[2:1] == {2{~q.osc_lvl}});
  assign osc_rise    = (q.osc_s[2:1] == 2'b11) && !q.osc_lvl;
  assign pll_restart = (q.sw_state == ccgms_pkg::SW_HOLD) || (ratio_q.kind != ccgms_pkg::KIND_PLL);

  ccgms_pll #(
    .PER_W    (PER_W)
  ) u_pll (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .restart  (pll_restart),
    .mul_num  (ratio_q.num),
    .mul_den  (ratio_q.den),
    .osc_rise (osc_rise),
    .osc_edge (osc_edge),
    .clk_out  (pll_clk),
    .locked   (pll_locked),
    .period   (pll_period)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0]             wr_val;
    logic [ADDR_W-1:0]       wa;
    logic [ADDR_W-1:0]       ra;
    logic [2:0]              strap_val;
    ccgms_pkg::ccgms_ratio_t nr;
    wr_val    = '0;
    wa        = '0;
    ra        = '0;
    strap_val = '0;
    nr        = '0;
    d         = q;

    // pins: three stages, level accepted once stages two and three agree
    d.osc_s    = {q.osc_s[1:0], osc_in};
    d.strap_s1 = clock_mode_strap_pins;
    d.strap_s2 = q.strap_s1;
    d.strap_s3 = q.strap_s2;
    d.ehm_s    = {q.ehm_s[1:0], external_host_mode};
    if (q.osc_s[1] == q.osc_s[2]) begin
      d.osc_lvl = q.osc_s[2];
    end
    if (q.strap_s2 == q.strap_s3) begin
      d.strap_lvl = q.strap_s3;
    end
    if (q.ehm_s[1] == q.ehm_s[2]) begin
      d.ehm_lvl = q.ehm_s[2];
    end

    // straps caught once the synchronisers have filled after reset
    if (!q.strap_done) begin
      if (q.strap_cnt == ccgms_pkg::STRAP_WAIT) begin
        strap_val = q.strap_lvl;
        if (q.ehm_lvl) begin
          strap_val[ccgms_pkg::EMU_INV_BIT] = ~q.strap_lvl[ccgms_pkg::EMU_INV_BIT]; // R8
        end
        d.latch[ccgms_pkg::MODE_LSB +: 3] = strap_val;
        d.strap_done = 1'b1;
      end else begin
        d.strap_cnt = q.strap_cnt + 1'b1;
      end
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      wa        = {q.awaddr[ADDR_W-1:2], 2'b00};
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = ccgms_pkg::RESP_SLVERR;
      if (wa == ADDR_W'(ccgms_pkg::RSTCTL_OFF)) begin
        d.bresp = ccgms_pkg::RESP_OKAY;
        wr_val  = q.rstctl;
        for (int i = 0; i < 2; i++) begin
          if (q.wstrb[i]) begin
            wr_val[8*i +: 8] = q.wdata[8*i +: 8];
          end
        end
        // reload strobe is not stored, it only fires the copy
        d.rstctl                       = wr_val;
        d.rstctl[ccgms_pkg::RELOAD_BIT] = 1'b0;
        if (wr_val[ccgms_pkg::RELOAD_BIT]) begin
          d.latch = wr_val[ccgms_pkg::CFG_LSB +: 8]; // R1
        end
      end
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready  = !d.w_have && !d.bvalid;

    // read channel: one read in flight, answer a cycle after the address
    if (q.rvalid && s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      ra        = {s_axi_araddr[ADDR_W-1:2], 2'b00};
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = ccgms_pkg::RESP_OKAY;
      d.rdata   = '0;
      if (ra == ADDR_W'(ccgms_pkg::RSTCTL_OFF)) begin
        d.rdata = {16'h0000, q.rstctl};
      end else if (ra == ADDR_W'(ccgms_pkg::LATCH_OFF)) begin
        d.rdata = {24'h000000, q.latch};
      end else if (ra == ADDR_W'(ccgms_pkg::STATUS_OFF)) begin
        d.rdata = {pll_period, 9'h000, pll_locked, q.ehm_lvl, q.pll_en,
                   (q.sw_state == ccgms_pkg::SW_HOLD), q.active};
      end else begin
        d.rresp = ccgms_pkg::RESP_SLVERR;
      end
    end

    // mode switch: leave the old path only while the cpu clock is low
    unique case (q.sw_state)
      ccgms_pkg::SW_RUN: begin
        if (q.latch[ccgms_pkg::MODE_LSB +: 3] != q.active && !q.cpu_clk) begin
          d.sw_state = ccgms_pkg::SW_HOLD; // R9
          d.settle   = 8'(ccgms_pkg::MODE_SETTLE_CYC);
        end
      end
      ccgms_pkg::SW_HOLD: begin
        // resume on a low oscillator so direct drive cannot start with a runt
        if (q.settle != '0) begin
          d.settle = q.settle - 1'b1;
        end else if (!q.osc_lvl) begin
          d.active   = q.latch[ccgms_pkg::MODE_LSB +: 3]; // R9
          d.sw_state = ccgms_pkg::SW_RUN;
        end
      end
    endcase

    // cpu clock from the path of the running mode
    nr = ccgms_pkg::ccgms_decode(q.active);
    if (d.sw_state == ccgms_pkg::SW_HOLD || q.sw_state == ccgms_pkg::SW_HOLD) begin
      d.cpu_clk = 1'b0; // R9
    end else begin
      unique case (nr.kind)
        ccgms_pkg::KIND_DIRECT: begin
          d.cpu_clk = q.osc_lvl;
        end
        ccgms_pkg::KIND_PRESCALE: begin
          // one toggle per oscillator rise: each phase is one input period
          if (osc_rise) begin
            d.cpu_clk = ~q.cpu_clk; // R3 R4
          end
        end
        ccgms_pkg::KIND_PLL: begin
          d.cpu_clk = pll_clk; // R5
        end
      endcase
    end
    nr       = ccgms_pkg::ccgms_decode(d.active);
    d.pll_en = (nr.kind == ccgms_pkg::KIND_PLL); // R5
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.rstctl   <= ccgms_pkg::RSTCTL_RESET;
      q.latch    <= ccgms_pkg::LATCH_RESET;
      q.active   <= ccgms_pkg::MODE_X4;
      q.sw_state <= ccgms_pkg::SW_RUN;
      q.pll_en   <= 1'b1;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign cpu_clk       = q.cpu_clk;
  assign pll_enable    = q.pll_en;

endmodule : ccgms_top

// ==== test/ccgms_properties.sv ====
`timescale 1ns/1ps
// ----------------------------------------------
// bus answer and cpu clock checks
// ----------------------------------------------
module ccgms_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // clock tree
  input wire logic        cpu_clk,
  input wire logic        pll_enable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // write taken in one edge, answer within two
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_write_answer;
    ##[1:2] s_axi_bvalid;
  endsequence

  a_write_answer: assert property (s_write_taken |-> s_write_answer)
    else $error("write not answered in time");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata moved early");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while rvalid");
  a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == ccgms_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // a runt shows as two changes running
  a_no_runt: assert property ($changed(cpu_clk) |=> $stable(cpu_clk))
    else $error("one-cycle cpu phase");
  a_switch_low: assert property ($changed(pll_enable) |-> !$past(cpu_clk))
    else $error("path changed with cpu clock high");
endmodule : ccgms_checker

// ==== test/ccgms_osc_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------
// free running oscillator source
// ----------------------------------------------
module ccgms_osc_model (
  // system clock
  input wire logic       aclk,
  // half period in aclk cycles
  input wire logic [7:0] half_cyc,
  // pin
  output logic           osc_in
);
  logic [7:0] cnt_q = 8'h0;

  initial osc_in = 1'b0;

  // a crystal runs free
  always @(posedge aclk) begin
    if (cnt_q + 8'h1 >= half_cyc) begin
      cnt_q <= 8'h0;
      osc_in <= ~osc_in;
    end else begin
      cnt_q <= cnt_q + 8'h1;
    end
  end
endmodule : ccgms_osc_model

// ==== test/ccgms_top_test.sv ====
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", what, exp, got); end end
// ----------------------------------------------
// register and clock path bench
// ----------------------------------------------
module ccgms_top_test;
  localparam int HALF = 20;
  logic aclk, aresetn, osc_in, external_host_mode, cpu_clk, pll_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, half_cyc;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  clock_mode_strap_pins;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_count = 0, checks_done = 0;
  // pll modes and rises in 8 osc periods
  logic [2:0]  pm [3] = '{ccgms_pkg::MODE_X4, ccgms_pkg::MODE_X2_5, ccgms_pkg::MODE_X5};
  logic [15:0] pe [3] = '{16'h0020, 16'h0014, 16'h0028};

  ccgms_top ccgms_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .osc_in(osc_in), .clock_mode_strap_pins(clock_mode_strap_pins),
    .external_host_mode(external_host_mode), .cpu_clk(cpu_clk), .pll_enable(pll_enable));
  ccgms_osc_model ccgms_osc_model_i (.aclk(aclk), .half_cyc(half_cyc), .osc_in(osc_in));

  always #10 aclk = ~aclk;

  // ----------------------------------------------
  // bus tasks
  // ----------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // latch reload via control register
  task automatic reload(input logic [2:0] m);
    logic [1:0] r;
    axi_write(ccgms_pkg::RSTCTL_OFF, {16'h0, m, 5'h0, 8'h01}, r);
    `CHK("reload resp", ccgms_pkg::RESP_OKAY, r)
  endtask : reload

  // poll until mode runs, locked if pll
  task automatic wait_mode(input logic [2:0] m);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    n = 0;
    do begin
      axi_read(ccgms_pkg::STATUS_OFF, s, r);
      n++;
    end while ((s[2:0] !== m || s[3] !== 1'b0 || (s[4] === 1'b1 && s[6] !== 1'b1)) && n < 200);
    if (n >= 200) err_count++;
  endtask : wait_mode

  task automatic phases(output logic [15:0] hi, output logic [15:0] lo);
    hi = 16'h0;
    lo = 16'h0;
    while (cpu_clk !== 1'b0) @(posedge aclk);
    while (cpu_clk === 1'b0) @(posedge aclk);
    while (cpu_clk === 1'b1) begin @(posedge aclk); hi++; end
    while (cpu_clk === 1'b0) begin @(posedge aclk); lo++; end
  endtask : phases

  task automatic count_rises(input int cyc, output logic [15:0] c);
    logic p;
    c = 16'h0;
    p = cpu_clk;
    repeat (cyc) begin
      @(posedge aclk);
      if (cpu_clk === 1'b1 && p === 1'b0) c++;
      p = cpu_clk;
    end
  endtask : count_rises

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // watchdog, sequence needs far less
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    conclude();
  end

  // ----------------------------------------------
  // test sequence
  // ----------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [15:0] hi, lo, c, prev;
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h3;
    clock_mode_strap_pins = 3'h7;
    external_host_mode = 1'b0;
    half_cyc = 8'(HALF);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    axi_read(ccgms_pkg::RSTCTL_OFF, d, r);
    `CHK("control reset", {16'h0, ccgms_pkg::RSTCTL_RESET}, d)
    axi_read(ccgms_pkg::LATCH_OFF, d, r);
    `CHK("latch reset", {24'h0, ccgms_pkg::LATCH_RESET}, d)
    `CHK("default path", 1'b1, pll_enable)
    // unmapped read, read-only write refused
    axi_read(8'h0c, d, r);
    `CHK("unmapped resp", ccgms_pkg::RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, d)
    axi_write(ccgms_pkg::LATCH_OFF, 32'h0000_00ff, r);
    `CHK("latch write resp", ccgms_pkg::RESP_SLVERR, r)
    axi_read(ccgms_pkg::LATCH_OFF, d, r);
    `CHK("latch kept", {24'h0, ccgms_pkg::LATCH_RESET}, d)
    // every mode code through the latch
    for (int i = 0; i < 8; i++) begin
      reload(3'(i));
      axi_read(ccgms_pkg::LATCH_OFF, d, r);
      `CHK("latch mode", {24'h0, 3'(i), 5'h0}, d)
      wait_mode(3'(i));
      `CHK("pll path", 1'(i != 3 && i != 1), pll_enable)
    end
    // prescaler phase one osc period, direct follows
    reload(ccgms_pkg::MODE_PRESCALE);
    wait_mode(ccgms_pkg::MODE_PRESCALE);
    phases(hi, lo);
    `CHK("prescale high", 16'(2 * HALF), hi)
    `CHK("prescale low", 16'(2 * HALF), lo)
    reload(ccgms_pkg::MODE_DIRECT);
    wait_mode(ccgms_pkg::MODE_DIRECT);
    phases(hi, lo);
    `CHK("direct high", 16'(HALF), hi)
    // pll rates over 8 osc periods, slack one
    for (int i = 0; i < 3; i++) begin
      reload(pm[i]);
      wait_mode(pm[i]);
      count_rises(16 * HALF, c);
      `CHK("pll rate", 1'b1, (c + 16'h1 >= pe[i] && c <= pe[i] + 16'h1))
    end
    axi_read(ccgms_pkg::STATUS_OFF, d, r);
    `CHK("measured period", 16'(2 * HALF), d[31:16])
    // slower osc, tracked one step a time
    prev = d[31:16];
    half_cyc <= 8'(HALF + 2);
    repeat (16) begin
      repeat (20) @(posedge aclk);
      axi_read(ccgms_pkg::STATUS_OFF, d, r);
      `CHK("period step", 1'b1, (d[31:16] <= prev + 16'h1 && d[31:16] + 16'h1 >= prev))
      prev = d[31:16];
    end
    `CHK("period tracked", 16'(2 * HALF + 4), d[31:16])
    // host mode inverts top strap on capture
    external_host_mode <= 1'b1;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    axi_read(ccgms_pkg::LATCH_OFF, d, r);
    `CHK("host strap", 32'h0000_0060, d)
    wait_mode(ccgms_pkg::MODE_DIRECT);
    `CHK("host direct", 1'b0, pll_enable)
    reload(ccgms_pkg::MODE_X4);
    axi_read(ccgms_pkg::LATCH_OFF, d, r);
    `CHK("host reload", 32'h0000_00e0, d)
    conclude();
  end
endmodule : ccgms_top_test

bind ccgms_top ccgms_checker ccgms_checker_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cpu_clk(cpu_clk), .pll_enable(pll_enable));
